// ---- hdl/crf_pkg.sv ----
package crf_pkg;
   localparam int NUM_CH = 8;
   localparam int WORD_W = 16;
   // APB byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RESOL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RECCNT = 8'h0C;
   localparam logic [7:0] ADDR_DROPCNT = 8'h10;
   // Control fields
   localparam int CTRL_CHEN_LSB = 0;
   localparam int CTRL_RANGE_BIT = 8;
   localparam int CTRL_STAMP_BIT = 9;
   localparam int CTRL_MODE_BIT = 10;
   localparam int CTRL_FILT_BIT = 11;
   localparam int CTRL_ACQ_BIT = 12;
   localparam logic [12:0] CTRL_RESET = 13'h00FF;
   localparam logic [15:0] RESOL_RESET = 16'h0013;
   // Status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LEN_LSB = 4;
   // Header layout
   localparam logic [2:0] REC_TYPE_NORMAL = 3'b100;
   localparam logic [4:0] HDR_RESERVED = 5'h00;
   localparam logic [4:0] LIB_NONE = 5'h00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [3:0] CH_NONE = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_CHAN = 3'b010,
      ST_RANGE = 3'b011,
      ST_STU = 3'b100,
      ST_STL = 3'b101
   } crf_state_type;

   // First enabled channel at or above start; CH_NONE if none
   function automatic logic [3:0] first_ch(input logic [7:0] mask, input logic [3:0] start);
      logic [3:0] r;
      r = CH_NONE;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i] && (4'(i) >= start)) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Record length in words
   function automatic logic [3:0] rec_len(input logic [7:0] mask, input logic rng, input logic stp);
      logic [3:0] n;
      n = 4'h1;
      for (int i = 0; i < NUM_CH; i++) begin
         n = n + {3'b000, mask[i]};
      end
      return n + {3'b000, rng} + {2'b00, stp, 1'b0};
   endfunction
endpackage

// ---- hdl/crf_count_bank.sv ----
module crf_count_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic clear,
   input wire logic snap,
   input wire logic [7:0] pulse,
   input wire logic [7:0] in_fault,
   output logic [7:0][15:0] count_snap_q,
   output logic [7:0] ovf_snap_q,
   output logic [7:0] err_snap_q
);
   logic [7:0][15:0] acc_q, acc_d, count_snap_d;
   logic [7:0] ovf_q, ovf_d, err_q, err_d, ovf_snap_d, err_snap_d;

   always_comb begin
      acc_d = acc_q;
      ovf_d = ovf_q;
      err_d = err_q;
      count_snap_d = count_snap_q;
      ovf_snap_d = ovf_snap_q;
      err_snap_d = err_snap_q;
      if (snap) begin
         count_snap_d = acc_q;
         ovf_snap_d = ovf_q;
         err_snap_d = err_q;
      end
      for (int i = 0; i < 8; i++) begin
         if (clear || snap) begin
            acc_d[i] = '0;
            ovf_d[i] = 1'b0;
            err_d[i] = 1'b0;
         end
         if (run && !clear) begin
            if (pulse[i]) begin
               if (acc_d[i] == crf_pkg::CNT_MAX) begin
                  ovf_d[i] = 1'b1;
               end else begin
                  acc_d[i] = acc_d[i] + 16'h0001;
               end
            end
            if (in_fault[i]) begin
               err_d[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= '0;
         ovf_q <= '0;
         err_q <= '0;
         count_snap_q <= '0;
         ovf_snap_q <= '0;
         err_snap_q <= '0;
      end else begin
         acc_q <= acc_d;
         ovf_q <= ovf_d;
         err_q <= err_d;
         count_snap_q <= count_snap_d;
         ovf_snap_q <= ovf_snap_d;
         err_snap_q <= err_snap_d;
      end
   end
endmodule // crf_count_bank

// ---- hdl/crf_stamp_timer.sv ----
module crf_stamp_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic clear,
   input wire logic time_mode,
   input wire logic [15:0] resol_div,
   input wire logic trig_taken,
   output logic [31:0] stamp_q
);
   logic [31:0] stamp_d;
   logic [15:0] pre_q, pre_d;

   always_comb begin
      stamp_d = stamp_q;
      pre_d = pre_q;
      if (clear) begin
         stamp_d = '0;
         pre_d = '0;
      end else if (run) begin
         if (time_mode) begin
            if (pre_q >= resol_div) begin
               pre_d = '0;
               stamp_d = stamp_q + 32'h0000_0001;
            end else begin
               pre_d = pre_q + 16'h0001;
            end
         end else if (trig_taken) begin
            stamp_d = stamp_q + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_q <= '0;
         pre_q <= '0;
      end else begin
         stamp_q <= stamp_d;
         pre_q <= pre_d;
      end
   end
endmodule // crf_stamp_timer

// ---- hdl/crf_formatter.sv ----
// Behaviour
// - One record per taken trigger, built of whole 16-bit words.
// - Header word first, then channel count words, then optional trailing words.
// - Count words in ascending channel order; disabled channels give no word.
// - Count words are unsigned 16-bit magnitudes, LSB at bit 0.
// - Count word equals counts gathered on that channel in the trigger period.
// - Header bits 15:13 hold record type 100 for a normal record.
// - Header bit 12 flags any overflow on an enabled channel, bit 11 any input fault on an enabled channel.
// - Header bits 10:6 are reserved and carry no meaning.
// - Header bit 5 set only on filter match with filtering enabled.
// - Header bits 4:0 hold match library number, zero otherwise.
// - Range word follows count words when range reporting is enabled.
// - Stamp is 32 bits, upper word sent before lower word.
// - Both stamp words left out when stamp reporting is off.
// - Time mode stamp counts resolution units from acquisition start.
// - Length is 1 plus channels plus range enable plus twice stamp enable.
// - Eight channels give at most 12 words, 9 without range and stamp.
// - Overflow means the count passed the accumulator maximum.
module crf_formatter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger,
   input wire logic [7:0] pulse,
   input wire logic [7:0] in_fault,
   input wire logic filter_match,
   input wire logic [4:0] filter_lib,
   output logic [15:0] rec_data,
   output logic rec_valid,
   output logic rec_last,
   input wire logic rec_ready
);
   logic [12:0] ctrl_q, ctrl_d;
   logic [15:0] resol_q, resol_d;
   logic [31:0] reccnt_q, reccnt_d;
   logic [31:0] dropcnt_q, dropcnt_d;
   logic [31:0] prdata_q, prdata_d;
   logic acq_q, acq_d;
   crf_pkg::crf_state_type st_q, st_d;
   logic [3:0] ch_q, ch_d;
   logic [15:0] data_q, data_d;
   logic last_q, last_d;
   logic [7:0] mask_q, mask_d;
   logic rng_q, rng_d;
   logic stp_q, stp_d;
   logic match_q, match_d;
   logic [4:0] lib_q, lib_d;
   logic [31:0] stamp_snap_q, stamp_snap_d;
   logic [7:0][15:0] cnt_snap;
   logic [7:0] ovf_snap;
   logic [7:0] err_snap;
   logic [31:0] stamp_now;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic acq_start;
   logic run;
   logic take;
   logic drop;
   logic adv;
   logic load;
   logic [3:0] len_now;
   logic [3:0] ch_first;
   logic [3:0] ch_next;
   logic [15:0] head_word;
   logic [15:0] range_word;
   logic overflow_flag;
   logic fault_flag;
   logic [4:0] hdr_lib;
   logic [15:0] stamp_upper_word;
   logic [15:0] stamp_lower_word;
   logic stamp_report_enable;

   // APB decode
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   always_comb begin
      unique case (paddr)
         crf_pkg::ADDR_CTRL, crf_pkg::ADDR_RESOL, crf_pkg::ADDR_STATUS,
         crf_pkg::ADDR_RECCNT, crf_pkg::ADDR_DROPCNT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   // Register write
   always_comb begin
      ctrl_d = ctrl_q;
      resol_d = resol_q;
      if (wr_en && paddr == crf_pkg::ADDR_CTRL) begin
         ctrl_d = pwdata[12:0];
      end
      if (wr_en && paddr == crf_pkg::ADDR_RESOL) begin
         resol_d = pwdata[15:0];
      end
   end

   // Register read
   always_comb begin
      prdata_d = prdata_q;
      if (rd_en) begin
         unique case (paddr)
            crf_pkg::ADDR_CTRL: prdata_d = {19'h0_0000, ctrl_q};
            crf_pkg::ADDR_RESOL: prdata_d = {16'h0000, resol_q};
            crf_pkg::ADDR_STATUS: prdata_d = {24'h00_0000, len_now, 3'b000, rec_valid};
            crf_pkg::ADDR_RECCNT: prdata_d = reccnt_q;
            crf_pkg::ADDR_DROPCNT: prdata_d = dropcnt_q;
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Acquisition control
   assign run = ctrl_q[crf_pkg::CTRL_ACQ_BIT];
   assign acq_d = run;
   assign acq_start = run && !acq_q;
   assign take = run && trigger && (st_q == crf_pkg::ST_IDLE);
   assign drop = run && trigger && (st_q != crf_pkg::ST_IDLE);
   assign stamp_report_enable = ctrl_q[crf_pkg::CTRL_STAMP_BIT];
   assign len_now = crf_pkg::rec_len(ctrl_q[7:0], ctrl_q[crf_pkg::CTRL_RANGE_BIT],
                                     stamp_report_enable);

   crf_count_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .clear(acq_start),
      .snap(take),
      .pulse(pulse),
      .in_fault(in_fault),
      .count_snap_q(cnt_snap),
      .ovf_snap_q(ovf_snap),
      .err_snap_q(err_snap)
   );

   crf_stamp_timer u_stamp (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .clear(acq_start),
      .time_mode(ctrl_q[crf_pkg::CTRL_MODE_BIT]),
      .resol_div(resol_q),
      .trig_taken(take),
      .stamp_q(stamp_now)
   );

   // Per-record snapshot of settings
   always_comb begin
      mask_d = mask_q;
      rng_d = rng_q;
      stp_d = stp_q;
      match_d = match_q;
      lib_d = lib_q;
      stamp_snap_d = stamp_snap_q;
      if (take) begin
         mask_d = ctrl_q[7:0];
         rng_d = ctrl_q[crf_pkg::CTRL_RANGE_BIT];
         stp_d = stamp_report_enable;
         match_d = filter_match && ctrl_q[crf_pkg::CTRL_FILT_BIT];
         lib_d = filter_lib;
         stamp_snap_d = stamp_now;
      end
   end

   // Header fields from this record's snapshot
   assign overflow_flag = |(ovf_snap & mask_q);
   assign fault_flag = |(err_snap & mask_q);
   assign hdr_lib = match_q ? lib_q : crf_pkg::LIB_NONE;
   assign stamp_upper_word = stamp_snap_q[31:16];
   assign stamp_lower_word = stamp_snap_q[15:0];

   // Header and range words
   always_comb begin
      head_word = {crf_pkg::REC_TYPE_NORMAL,
                   overflow_flag,
                   fault_flag,
                   crf_pkg::HDR_RESERVED,
                   match_q,
                   hdr_lib};
      range_word = {err_snap, ovf_snap};
   end

   // Word sequencer
   assign adv = rec_valid && rec_ready;
   assign ch_first = crf_pkg::first_ch(mask_q, 4'h0);
   assign ch_next = crf_pkg::first_ch(mask_q, ch_q + 4'h1);

   always_comb begin
      st_d = st_q;
      ch_d = ch_q;
      load = 1'b0;
      unique case (st_q)
         crf_pkg::ST_IDLE: begin
            if (take) begin
               st_d = crf_pkg::ST_HEAD;
            end
         end
         crf_pkg::ST_HEAD: begin
            if (adv) begin
               ch_d = ch_first;
            end
         end
         crf_pkg::ST_CHAN: begin
            if (adv) begin
               ch_d = ch_next;
            end
         end
         crf_pkg::ST_RANGE, crf_pkg::ST_STU, crf_pkg::ST_STL: begin
         end
         default: begin
            st_d = crf_pkg::ST_IDLE;
         end
      endcase
      if (adv) begin
         load = 1'b1;
         if (st_q == crf_pkg::ST_STL || rec_last) begin
            st_d = crf_pkg::ST_IDLE;
         end else if ((st_q == crf_pkg::ST_HEAD || st_q == crf_pkg::ST_CHAN)
                      && ch_d != crf_pkg::CH_NONE) begin
            st_d = crf_pkg::ST_CHAN;
         end else if ((st_q == crf_pkg::ST_HEAD || st_q == crf_pkg::ST_CHAN) && rng_q) begin
            st_d = crf_pkg::ST_RANGE;
         end else if (st_q == crf_pkg::ST_STU) begin
            st_d = crf_pkg::ST_STL;
         end else begin
            st_d = crf_pkg::ST_STU;
         end
      end
   end

   // Output word for the next state
   always_comb begin
      data_d = data_q;
      last_d = last_q;
      if (st_q == crf_pkg::ST_IDLE && take) begin
         last_d = 1'b0;
      end
      if (load || st_q == crf_pkg::ST_IDLE) begin
         unique case (st_d)
            crf_pkg::ST_HEAD: data_d = head_word;
            crf_pkg::ST_CHAN: data_d = cnt_snap[ch_d[2:0]];
            crf_pkg::ST_RANGE: data_d = range_word;
            crf_pkg::ST_STU: data_d = stamp_upper_word;
            crf_pkg::ST_STL: data_d = stamp_lower_word;
            default: data_d = 16'h0000;
         endcase
      end
      if (load) begin
         unique case (st_d)
            crf_pkg::ST_CHAN: last_d = !rng_q && !stp_q
                                       && crf_pkg::first_ch(mask_q, ch_d + 4'h1) == crf_pkg::CH_NONE;
            crf_pkg::ST_RANGE: last_d = !stp_q;
            crf_pkg::ST_STL: last_d = 1'b1;
            default: last_d = 1'b0;
         endcase
      end
   end

   // Header-only record when nothing follows
   logic head_last;
   assign head_last = (mask_q == 8'h00) && !rng_q && !stp_q;

   assign rec_valid = (st_q != crf_pkg::ST_IDLE);
   // Header read live so it carries the snapshot of its own trigger
   always_comb begin
      rec_data = data_q;
      if (st_q == crf_pkg::ST_HEAD) begin
         rec_data = head_word;
      end
   end
   assign rec_last = rec_valid && (last_q || (st_q == crf_pkg::ST_HEAD && head_last));

   // Record counters
   always_comb begin
      reccnt_d = reccnt_q;
      dropcnt_d = dropcnt_q;
      if (acq_start) begin
         reccnt_d = '0;
         dropcnt_d = '0;
      end else begin
         if (adv && rec_last) begin
            reccnt_d = reccnt_q + 32'h0000_0001;
         end
         if (drop) begin
            dropcnt_d = dropcnt_q + 32'h0000_0001;
         end
      end
   end

   // Register file state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= crf_pkg::CTRL_RESET;
         resol_q <= crf_pkg::RESOL_RESET;
         reccnt_q <= '0;
         dropcnt_q <= '0;
         prdata_q <= '0;
         acq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         resol_q <= resol_d;
         reccnt_q <= reccnt_d;
         dropcnt_q <= dropcnt_d;
         prdata_q <= prdata_d;
         acq_q <= acq_d;
      end
   end

   // Record state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= crf_pkg::ST_IDLE;
         ch_q <= '0;
         data_q <= '0;
         last_q <= 1'b0;
         mask_q <= '0;
         rng_q <= 1'b0;
         stp_q <= 1'b0;
         match_q <= 1'b0;
         lib_q <= '0;
         stamp_snap_q <= '0;
      end else begin
         st_q <= st_d;
         ch_q <= ch_d;
         data_q <= data_d;
         last_q <= last_d;
         mask_q <= mask_d;
         rng_q <= rng_d;
         stp_q <= stp_d;
         match_q <= match_d;
         lib_q <= lib_d;
         stamp_snap_q <= stamp_snap_d;
      end
   end
endmodule // crf_formatter

// ---- verif/crf_formatter_props.sv ----
module crf_formatter_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic trigger,
   input wire logic filter_match,
   input wire logic [4:0] filter_lib,
   input wire logic [15:0] rec_data,
   input wire logic rec_valid,
   input wire logic rec_last,
   input wire logic rec_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] idx_q, idx_d;
   // Word index within a record
   always_comb begin
      idx_d = idx_q;
      if (rec_valid && rec_ready) begin
         idx_d = rec_last ? 4'h0 : idx_q + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= 4'h0;
      end else begin
         idx_q <= idx_d;
      end
   end
   sequence s_hdr;
      $rose(rec_valid);
   endsequence
   sequence s_held;
      rec_valid && !rec_ready;
   endsequence
   property p_type; s_hdr |-> rec_data[15:13] == 3'b100; endproperty
   a_type: assert property (p_type) else $error("bad record type");
   property p_rsv; s_hdr |-> rec_data[10:6] == 5'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_cause; s_hdr |-> $past(trigger) && idx_q == 4'h0; endproperty
   a_cause: assert property (p_cause) else $error("record without trigger");
   property p_match; s_hdr ##0 rec_data[5] |-> $past(filter_match) && rec_data[4:0] == $past(filter_lib); endproperty
   a_match: assert property (p_match) else $error("match flag wrong");
   property p_nolib; s_hdr ##0 !rec_data[5] |-> rec_data[4:0] == 5'h00; endproperty
   a_nolib: assert property (p_nolib) else $error("library field wrong");
   property p_hold; s_held |=> rec_valid && $stable(rec_data) && $stable(rec_last); endproperty
   a_hold: assert property (p_hold) else $error("word changed while held");
   property p_end; rec_valid && rec_ready && rec_last |=> !rec_valid; endproperty
   a_end: assert property (p_end) else $error("no gap after record");
   property p_max; rec_valid |-> idx_q <= 4'hB; endproperty
   a_max: assert property (p_max) else $error("record too long");
   property p_apb; psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |-> pready && pslverr;
   endproperty
   a_apb: assert property (p_apb) else $error("unmapped access not refused");
endmodule // crf_formatter_props

// ---- verif/crf_host_sink.sv ----
module crf_host_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] rec_data,
   input wire logic rec_valid,
   input wire logic rec_last,
   input wire logic slow,
   input wire logic stall,
   output logic rec_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] log_mem [int];
   logic [15:0] cur [$];
   logic [15:0] last_rec [$];
   logic tog = 1'b0;
   int wr_ptr = 2033, rec_base = 2033, rec_len = 0, n_rec = 0;
   assign rec_ready = !stall && !(slow && tog);
   // Records logged back to back; range bits kept raw, never interpreted
   always @(posedge pclk) begin
      tog <= ~tog;
      if (presetn && rec_valid && rec_ready) begin
         log_mem[wr_ptr] = rec_data;
         cur.push_back(rec_data);
         wr_ptr++;
         if (rec_last) begin
            last_rec = cur;
            rec_len = cur.size();
            rec_base = wr_ptr - rec_len;
            cur = {};
            n_rec++;
         end
      end
   end
endmodule // crf_host_sink

// ---- verif/crf_formatter_tb.sv ----
module crf_formatter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trigger = 0, filter_match = 0;
   logic [7:0] paddr = 8'h00, pulse = 8'h00, in_fault = 8'h00, m, ovf, flt;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q, s1;
   logic pready, pslverr, rec_valid, rec_last, rec_ready, e, rg, st, tm, fe, slow = 0, stall = 0;
   logic [4:0] filter_lib = 5'h00;
   logic [15:0] rec_data;
   logic [15:0] c [8];
   logic [15:0] ex [$];
   int failures = 0, n_compared = 0, n_taken = 0, ptr = 2033, cyc = 0, t0;
`define CK(g_, e_) begin n_compared++; if ((g_) !== (e_)) begin failures++; \
   $display("Error %0t got %h exp %h", $time, g_, e_); end end
   always #25 pclk = ~pclk;
   always @(negedge pclk) cyc++;
   crf_formatter DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .trigger, .pulse, .in_fault, .filter_match, .filter_lib, .rec_data, .rec_valid, .rec_last, .rec_ready);
   crf_host_sink host (.pclk, .presetn, .rec_data, .rec_valid, .rec_last, .slow, .stall, .rec_ready);
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic set(input logic [7:0] mm, input logic r, s, t, f);
      {m, rg, st, tm, fe} = {mm, r, s, t, f};
      apb(1'b1, 8'h00, {19'h0_0000, 1'b1, f, t, s, r, mm});
   endtask
   task automatic pulses();
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 8; i++) pulse[i] <= (k <= i);
         @(posedge pclk);
      end
      pulse <= 8'h00;
      for (int i = 0; i < 8; i++) c[i] = 16'(i + 1);
   endtask
   task automatic fire(input logic fm, input logic [4:0] lib, input logic dup);
      int n0;
      n0 = host.n_rec;
      ex = {};
      ex.push_back({3'b100, |(ovf & m), |(flt & m), 5'h00, fm & fe, (fm & fe) ? lib : 5'h00});
      for (int i = 0; i < 8; i++) if (m[i]) ex.push_back(c[i]);
      if (rg) ex.push_back({flt, ovf});
      if (st) ex.push_back(16'(n_taken >> 16));
      if (st) ex.push_back(16'(n_taken));
      trigger <= 1'b1;
      filter_match <= fm;
      filter_lib <= lib;
      stall <= dup;
      t0 = cyc;
      @(posedge pclk);
      trigger <= 1'b0;
      if (dup) begin
         repeat (3) @(posedge pclk);
         trigger <= 1'b1;
         @(posedge pclk);
         trigger <= 1'b0;
         stall <= 1'b0;
      end
      for (int k = 0; k < 300 && host.n_rec == n0; k++) @(posedge pclk);
      n_taken++;
      `CK(host.n_rec, n0 + 1)
      `CK(host.rec_len, ex.size())
      `CK(host.rec_base, ptr)
      ptr += ex.size();
      for (int i = 0; i < ex.size() - 2 * (st & tm); i++) `CK(host.last_rec[i], ex[i])
      for (int i = 0; i < 8; i++) c[i] = 16'h0000;
      @(posedge pclk);
   endtask
   task automatic s_regs();
      apb(1'b0, 8'h00, 32'h0000_0000);
      `CK(q, 32'h0000_00FF)
      apb(1'b0, 8'h04, 32'h0000_0000);
      `CK(q, 32'h0000_0013)
      apb(1'b0, 8'h08, 32'h0000_0000);
      `CK(q, 32'h0000_0090)
      apb(1'b1, 8'h20, 32'h0000_0001);
      `CK(e, 1'b1)
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CK(q, 32'h0000_0000)
      apb(1'b1, 8'h04, 32'h0000_0003);
      apb(1'b0, 8'h04, 32'h0000_0000);
      `CK(q, 32'h0000_0003)
   endtask
   task automatic s_full();
      set(8'hFF, 1'b1, 1'b1, 1'b0, 1'b1);
      slow <= 1'b1;
      flt = 8'h05;
      in_fault <= flt;
      pulses();
      in_fault <= 8'h00;
      fire(1'b1, 5'h0A, 1'b0);
      slow <= 1'b0;
      flt = 8'h00;
   endtask
   task automatic s_cfg();
      logic [9:0] tbl [4] = '{10'h3FC, 10'h297, 10'h000, 10'h16A};
      for (int j = 0; j < 4; j++) begin
         set(tbl[j][9:2], tbl[j][1], tbl[j][0], 1'b0, 1'b0);
         pulses();
         fire(1'b1, 5'h1F, 1'b0);
      end
   endtask
   task automatic s_ovf();
      set(8'h01, 1'b1, 1'b0, 1'b0, 1'b0);
      pulse <= 8'h01;
      repeat (65540) @(posedge pclk);
      pulse <= 8'h00;
      c[0] = 16'hFFFF;
      ovf = 8'h01;
      fire(1'b0, 5'h00, 1'b0);
      ovf = 8'h00;
   endtask
   task automatic s_drop();
      set(8'h03, 1'b0, 1'b1, 1'b0, 1'b0);
      fire(1'b0, 5'h00, 1'b1);
      apb(1'b0, 8'h10, 32'h0000_0000);
      `CK(q, 32'h0000_0001)
      apb(1'b0, 8'h0C, 32'h0000_0000);
      `CK(q, 32'(n_taken))
   endtask
   task automatic s_time();
      set(8'h01, 1'b0, 1'b1, 1'b1, 1'b0);
      fire(1'b0, 5'h00, 1'b0);
      s1 = {host.last_rec[2], host.last_rec[3]};
      while (cyc != t0 + 80) @(posedge pclk);
      fire(1'b0, 5'h00, 1'b0);
      `CK({host.last_rec[2], host.last_rec[3]} - s1, 32'h0000_0014)
   endtask
   task automatic final_report();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      {m, ovf, flt, rg, st, tm, fe} = '0;
      for (int i = 0; i < 8; i++) c[i] = 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_full();
      s_cfg();
      s_ovf();
      s_drop();
      s_time();
      final_report();
   end
   initial begin
      #4_500_000;
      failures++;
      final_report();
   end
endmodule // crf_formatter_tb
bind crf_formatter crf_formatter_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
   .trigger, .filter_match, .filter_lib, .rec_data, .rec_valid, .rec_last, .rec_ready);
